// ==== core/hpfa_top.sv ====
// Host port FIFO access block: APB registers, byte FIFO, DMA, USB, disk
`default_nettype none

module hpfa_top
  import hpfa_pkg::*;
#(
  parameter int DEPTH = 64
) (
  // Clock, reset, enable
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Host pins
  input  wire logic        dma_acknowledge_pin_i,
  input  wire logic        sleep_i,
  output logic             int_n_o,
  output logic             int_oe_o,
  output logic             dma_req_o,
  output logic      [1:0]  clock_source_choice_o,
  // USB data streams
  input  wire logic        usb_rx_valid_i,
  input  wire logic [7:0]  usb_rx_data_i,
  output logic             usb_rx_ready_o,
  output logic             usb_tx_valid_o,
  output logic      [7:0]  usb_tx_data_o,
  input  wire logic        usb_tx_ready_i,
  // USB transactions
  input  wire logic        usb_tok_i,
  input  wire logic [6:0]  usb_tok_addr_i,
  input  wire logic [3:0]  usb_tok_ep_i,
  input  wire logic        usb_tok_iso_i,
  input  wire logic        usb_tok_err_i,
  input  wire logic        usb_sof_i,
  output logic             usb_reply_valid_o,
  output hpfa_reply_e      usb_reply_o,
  // Disk data streams and pin control
  input  wire logic        disk_rx_valid_i,
  input  wire logic [7:0]  disk_rx_data_i,
  output logic             disk_rx_ready_o,
  output logic             disk_tx_valid_o,
  output logic      [7:0]  disk_tx_data_o,
  input  wire logic        disk_tx_ready_i,
  output logic      [1:0]  disk_drive_enable_o,
  output logic             disk_pullup_o,
  output logic             disk_pulldown_o,
  output logic      [1:0]  disk_mode_o,
  output logic             disk_busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  // DEPTH must be a power of two so pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] LV0 = '0;
  localparam logic [AW:0] LV2 = (AW+1)'(2);

  typedef struct packed {
    logic [31:0] rdata;
    logic [15:0] guard;
    logic [4:0]  setup;
    logic [1:0]  clk_src;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] level;
    logic [AW:0] snap;
    logic [2:0]  miss;
    logic [15:0] dma_cnt;
    logic [14:0] usb_cfg;
    logic [5:0]  disk_cfg;
    logic [15:0] disk_cnt;
    logic        disk_busy;
    logic        iso_done;
    logic        rep_v;
    hpfa_reply_e rep;
    logic        ack_m;
    logic        ack_s;
    logic        slp_m;
    logic        slp_s;
  } hpfa_state_s;

  hpfa_state_s q;
  hpfa_state_s d;
  logic [7:0]  mem_q [DEPTH];

  logic        setup_ph;
  logic        acc;
  logic        wr_ok;
  logic        rd_ok;
  logic        key_ok;
  logic        ack_idle;
  logic        dma_ok;
  logic        hit_flag;
  logic        int_act;
  logic        tok_ok;
  logic        usb_rx_go;
  logic        disk_rx_go;
  logic        usb_tx_go;
  logic        disk_tx_go;
  logic [1:0]  dma_n;
  logic [1:0]  push_n;
  logic [1:0]  pop_n;
  logic [7:0]  push_b0;
  logic [7:0]  push_b1;
  logic [7:0]  h0;
  logic [7:0]  h1;
  logic [AW:0] free;
  logic [15:0] lvl16;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and status terms
  // Phase decode, writes take both low bytes
  assign setup_ph = psel_i & ~penable_i;
  assign acc      = psel_i & penable_i & ce_i;
  assign wr_ok    = acc & pwrite_i & (|pstrb_i[1:0]);
  assign rd_ok    = acc & ~pwrite_i;
  assign key_ok   = (q.guard == GUARD_KEY);
  // Isolated pin reads as idle; DMA needs no acknowledge
  assign ack_idle = (q.setup[SU_ISO] & q.slp_s) |
                    (q.ack_s != q.setup[SU_ACKPOL]);
  assign dma_ok   = q.setup[SU_DMA] & ~q.setup[SU_CS] & ack_idle &
                    (q.dma_cnt != 16'h0000);
  assign dma_n    = (q.dma_cnt == 16'h0001) ? 2'd1 : 2'd2;
  // FIFO head and fill
  assign h0    = mem_q[q.rp];
  assign h1    = mem_q[q.rp + AW'(1)];
  assign free  = (AW+1)'(DEPTH) - q.level;
  assign lvl16 = 16'(q.level);
  // Flag shows when count settled or after four misses
  assign hit_flag = (q.level == q.snap) | (q.miss == MISS_MAX);
  // Link streams stand aside during host accesses
  assign usb_rx_ready_o  = ~psel_i & ~q.usb_cfg[UC_SRC] & (free != LV0);
  assign disk_rx_ready_o = ~psel_i & q.usb_cfg[UC_SRC] & q.disk_busy &
                           (free != LV0);
  assign usb_tx_valid_o  = ~psel_i & ~q.usb_cfg[UC_SNK] &
                           ~q.usb_cfg[UC_HOLD] & (q.level != LV0);
  assign disk_tx_valid_o = ~psel_i & q.usb_cfg[UC_SNK] & q.disk_busy &
                           (q.level != LV0);
  assign usb_tx_data_o   = h0;
  assign disk_tx_data_o  = h0;
  // Each path has its own handshake, neither waits on the other
  assign usb_rx_go  = ce_i & usb_rx_valid_i & usb_rx_ready_o;
  assign disk_rx_go = ce_i & disk_rx_valid_i & disk_rx_ready_o;
  assign usb_tx_go  = ce_i & usb_tx_valid_o & usb_tx_ready_i;
  assign disk_tx_go = ce_i & disk_tx_valid_o & disk_tx_ready_i;
  // Transaction acceptance checks
  assign tok_ok = usb_tok_i & q.usb_cfg[UC_CONF] & ~usb_tok_err_i &
                  (usb_tok_addr_i == q.usb_cfg[UC_ADDR +: 7]) &
                  (usb_tok_ep_i < q.usb_cfg[UC_EP +: 4]) &
                  ~(usb_tok_iso_i & q.iso_done);

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Interrupt active while a DMA run has finished
  assign int_act  = q.setup[SU_DMA] & (q.dma_cnt == 16'h0000);
  assign int_n_o  = q.setup[SU_INT_OD] ? 1'b0 : ~int_act;
  assign int_oe_o = q.setup[SU_INT_OD] ? int_act : 1'b1;
  // Bus answers at once while enabled, never with an error
  assign pready_o  = ce_i;
  assign pslverr_o = 1'b0;
  assign prdata_o  = q.rdata;
  // Disk pin control straight from registers
  assign disk_drive_enable_o = q.disk_cfg[1:0];
  assign disk_pullup_o       = q.disk_cfg[2];
  assign disk_pulldown_o     = q.disk_cfg[3];
  assign disk_mode_o         = q.disk_cfg[5:4];
  assign disk_busy_o         = q.disk_busy;
  // Miscellaneous
  assign dma_req_o             = q.setup[SU_DMA] & (q.dma_cnt != 16'h0000);
  assign clock_source_choice_o = q.clk_src;
  assign usb_reply_valid_o     = q.rep_v;
  assign usb_reply_o           = q.rep;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d       = q;
    push_n  = 2'd0;
    pop_n   = 2'd0;
    push_b0 = pwdata_i[7:0];
    push_b1 = pwdata_i[15:8];
    // Pin synchronisers
    d.ack_m = dma_acknowledge_pin_i;
    d.ack_s = q.ack_m;
    d.slp_m = sleep_i;
    d.slp_s = q.slp_m;
    // FIFO fill, host first then link
    if (wr_ok && paddr_i == A_FIFO_W && free >= LV2) begin
      push_n = 2'd2;
    end else if (wr_ok && paddr_i == A_DMA_WIN && dma_ok &&
                 free >= (AW+1)'(dma_n)) begin
      push_n    = dma_n;
      d.dma_cnt = q.dma_cnt - 16'(dma_n);
    end else if (usb_rx_go) begin
      push_n  = 2'd1;
      push_b0 = usb_rx_data_i;
    end else if (disk_rx_go) begin
      push_n  = 2'd1;
      push_b0 = disk_rx_data_i;
    end
    // FIFO drain, host first then link
    if (rd_ok && paddr_i == A_BYTE_POP && q.level != LV0) begin
      pop_n = 2'd1;
    end else if (rd_ok && paddr_i == A_FIFO_W && q.level >= LV2) begin
      pop_n = 2'd2;
    end else if (rd_ok && paddr_i == A_DMA_WIN && dma_ok &&
                 q.level >= (AW+1)'(dma_n)) begin
      pop_n     = dma_n;
      d.dma_cnt = q.dma_cnt - 16'(dma_n);
    end else if (usb_tx_go || disk_tx_go) begin
      pop_n = 2'd1;
    end
    d.wp    = q.wp + AW'(push_n);
    d.rp    = q.rp + AW'(pop_n);
    d.level = q.level + (AW+1)'(push_n) - (AW+1)'(pop_n);
    // Disk byte count and busy
    if (disk_rx_go || disk_tx_go) begin
      d.disk_cnt = q.disk_cnt - 16'h0001;
      if (q.disk_cnt == 16'h0001) begin
        d.disk_busy = 1'b0;
      end
    end
    // Read data captured in the setup phase
    if (setup_ph) begin
      case (paddr_i)
        A_GUARD:    d.rdata = {16'h0000, q.guard};
        A_SETUP:    d.rdata = 32'(q.setup);
        A_CLK:      d.rdata = 32'(q.clk_src);
        A_FIFO_W:   d.rdata = {16'h0000, h1, h0};
        A_BYTE_POP: d.rdata = {24'h00_0000, h0};
        A_REM_LO:   d.rdata = {24'h00_0000, lvl16[7:0]};
        A_REM_HI:   d.rdata = {16'h0000, hit_flag, 7'h00, lvl16[15:8]};
        A_DMA_CNT:  d.rdata = {16'h0000, q.dma_cnt};
        A_DMA_WIN:  d.rdata = (dma_n == 2'd1) ? {24'h00_0000, h0} :
                              {16'h0000, h1, h0};
        A_USB_CFG:  d.rdata = 32'(q.usb_cfg);
        A_DISK_CFG: d.rdata = 32'(q.disk_cfg);
        A_DISK_CNT: d.rdata = {16'h0000, q.disk_cnt};
        A_DISK_GO:  d.rdata = 32'(q.disk_busy);
        default:    d.rdata = 32'h0000_0000;
      endcase
    end
    // Remain-high read tracks misses
    if (rd_ok && paddr_i == A_REM_HI) begin
      d.snap = q.level;
      d.miss = hit_flag ? 3'h0 : q.miss + 3'h1;
    end
    // Register writes; guarded ones complete but are dropped
    if (wr_ok) begin
      case (paddr_i)
        A_GUARD:    d.guard = pwdata_i[15:0];
        A_SETUP:    if (key_ok) d.setup = pwdata_i[4:0];
        A_CLK:      if (key_ok) d.clk_src = pwdata_i[1:0];
        A_DMA_CNT:  d.dma_cnt = pwdata_i[15:0];
        A_USB_CFG:  d.usb_cfg = pwdata_i[14:0];
        A_DISK_CFG: d.disk_cfg = pwdata_i[5:0];
        A_DISK_CNT: d.disk_cnt = pwdata_i[15:0];
        A_DISK_GO:  if (pwdata_i[0]) d.disk_busy = (q.disk_cnt != 0);
        default:    ;
      endcase
    end
    // Transaction reply; isochronous limit reset each frame
    d.rep_v = 1'b0;
    if (usb_sof_i) begin
      d.iso_done = 1'b0;
    end
    if (tok_ok) begin
      d.rep_v = 1'b1;
      d.rep   = q.usb_cfg[UC_HOLD] ? RPL_NAK : RPL_ACK;
      if (usb_tok_iso_i) begin
        d.iso_done = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  // State register, frozen while enable is low, reset loads it even then
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      q          <= '0;
      q.setup    <= SETUP_RST;
      q.clk_src  <= CLK_RST;
      q.usb_cfg  <= USBCFG_RST;
      q.disk_cfg <= DISK_RST;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // FIFO storage, low byte first
  always_ff @(posedge core_clk_i) begin
    if (ce_i && push_n != 2'd0) begin
      mem_q[q.wp] <= push_b0;
    end
    if (ce_i && push_n == 2'd2) begin
      mem_q[q.wp + AW'(1)] <= push_b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  AST_INT_OD: assert property (
    (q.setup[SU_INT_OD] && int_act) |-> (int_oe_o && !int_n_o))
    else $error("open-drain interrupt not pulling low");
  AST_GUARD: assert property (
    (wr_ok && paddr_i == A_SETUP && !key_ok) |=> $stable(q.setup))
    else $error("guarded setup write took effect");
  AST_DMA_WIN: assert property (
    (wr_ok && paddr_i == A_DMA_WIN && dma_ok && q.dma_cnt > 16'h0001 &&
     free >= LV2) |=> (q.dma_cnt + 16'h0002 == $past(q.dma_cnt)))
    else $error("DMA window write did not count two bytes");
  AST_ISOLATE: assert property (
    (q.setup[SU_ISO] && q.slp_s && q.setup[SU_DMA] && !q.setup[SU_CS] &&
     q.dma_cnt != 16'h0000) |-> (dma_ok && (int_oe_o || q.setup[SU_INT_OD])))
    else $error("isolated acknowledge pin still gates DMA");
  AST_VALID5: assert property (
    (ce_i && setup_ph && paddr_i == A_REM_HI && q.miss == MISS_MAX)
    |=> q.rdata[15])
    else $error("valid flag missing on fifth read");
  AST_WIDE: assert property (
    (wr_ok && paddr_i == A_USB_CFG && pstrb_i[1:0] == 2'b10)
    |=> (q.usb_cfg[7:0] == $past(pwdata_i[7:0])))
    else $error("even byte not written with odd byte");
  AST_POP1: assert property (
    (rd_ok && paddr_i == A_BYTE_POP && q.level != LV0)
    |=> (q.level + (AW+1)'(1) == $past(q.level)))
    else $error("byte pop did not remove one byte");
  AST_ODD: assert property (
    (wr_ok && paddr_i == A_DMA_WIN && dma_ok && q.dma_cnt == 16'h0001 &&
     free != LV0) |=> (q.level == $past(q.level) + (AW+1)'(1) &&
                       q.dma_cnt == 16'h0000))
    else $error("odd DMA tail stored wrong byte count");
  AST_DISK_OFF: assert property (
    (wr_ok && paddr_i == A_DISK_CFG && pwdata_i[1:0] == 2'b00)
    |=> (disk_drive_enable_o == 2'b00))
    else $error("disk outputs still enabled");
  AST_NO_REPLY: assert property (
    (ce_i && usb_tok_i && usb_tok_err_i) |=> !usb_reply_valid_o)
    else $error("reply to errored packet");
  AST_ISO_ONE: assert property (
    (ce_i && usb_tok_i && usb_tok_iso_i && q.iso_done && !usb_sof_i)
    |=> !usb_reply_valid_o)
    else $error("second isochronous reply in a microframe");
  AST_NO_ERR: assert property (
    (psel_i && penable_i && ce_i) |-> (pready_o && !pslverr_o))
    else $error("access stalled or flagged an error");
  COV_ODD_DMA: cover property (
    wr_ok && paddr_i == A_DMA_WIN && dma_ok && q.dma_cnt == 16'h0001);
  COV_BYTE_POP: cover property (
    rd_ok && paddr_i == A_BYTE_POP && q.level != LV0);
  COV_ISO_REPLY: cover property (tok_ok && usb_tok_iso_i);

endmodule // hpfa_top

`default_nettype wire

// ==== core/hpfa_pkg.sv ====
// Package: constants for the host port FIFO access block
// Operation
// - Interrupt pin selectable push-pull or open-drain
// - Guard register gates setup and clock writes
// - DMA via window registers without acknowledge pin
// - Sleep isolation blocks the acknowledge input, outputs keep working
// - Valid flag seen within five remain-high reads
// - Write updates even and odd byte together
// - Byte pop removes exactly one head byte
// - Odd DMA count drops final upper byte
// - Disk transfer started by count and launch
// - Drive enable zero floats disk outputs
// - Disk pulls enabled only by register bits
// - Disk and USB paths never stall each other
// - Direct USB-disk transfer through internal FIFO
// - Host pushes whenever space, ignoring packets
// - Host pops whenever data, ignoring packets
// - No reply when unconfigured, invalid or errored
// - One isochronous transaction per microframe only
`default_nettype none

package hpfa_pkg;

  // Register byte offsets
  localparam logic [7:0] A_GUARD    = 8'h00;
  localparam logic [7:0] A_SETUP    = 8'h04;
  localparam logic [7:0] A_CLK      = 8'h08;
  localparam logic [7:0] A_FIFO_W   = 8'h0C;
  localparam logic [7:0] A_BYTE_POP = 8'h10;
  localparam logic [7:0] A_REM_LO   = 8'h14;
  localparam logic [7:0] A_REM_HI   = 8'h18;
  localparam logic [7:0] A_DMA_CNT  = 8'h1C;
  localparam logic [7:0] A_DMA_WIN  = 8'h20;
  localparam logic [7:0] A_USB_CFG  = 8'h24;
  localparam logic [7:0] A_DISK_CFG = 8'h28;
  localparam logic [7:0] A_DISK_CNT = 8'h2C;
  localparam logic [7:0] A_DISK_GO  = 8'h30;

  // Guard key, value arbitrary
  localparam logic [15:0] GUARD_KEY = 16'h0056;

  // Host setup field positions
  localparam int SU_INT_OD = 0;
  localparam int SU_DMA    = 1;
  localparam int SU_ACKPOL = 2;
  localparam int SU_CS     = 3;
  localparam int SU_ISO    = 4;

  // USB setup field positions
  localparam int UC_SRC  = 0;
  localparam int UC_SNK  = 1;
  localparam int UC_HOLD = 2;
  localparam int UC_CONF = 3;
  localparam int UC_ADDR = 4;
  localparam int UC_EP   = 11;

  // Values after reset
  localparam logic [4:0]  SETUP_RST  = 5'h00;
  localparam logic [1:0]  CLK_RST    = 2'h0;
  localparam logic [14:0] USBCFG_RST = 15'h0000;
  localparam logic [5:0]  DISK_RST   = 6'h00;

  // Remain-high reads before the flag is forced
  localparam logic [2:0] MISS_MAX = 3'h4;

  // Transaction reply codes
  typedef enum logic [1:0] {RPL_NONE, RPL_ACK, RPL_NAK} hpfa_reply_e;

endpackage

`default_nettype wire

// ==== verif/hpfa_host_bfm.sv ====
// Host processor model: APB master with one transfer task
`default_nettype none
module hpfa_host_bfm (
  // Clock
  input  wire logic        clk_i,
  // APB master
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic      [7:0]  paddr_o,
  output logic      [31:0] pwdata_o,
  output logic      [3:0]  pstrb_o,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bus idle at time zero
  initial begin
    {psel_o, penable_o, pwrite_o} = 3'b000;
    {paddr_o, pwdata_o, pstrb_o} = '0;
  end
  // Setup, access held until pready, then release
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    pstrb_o <= s;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    r = prdata_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    pwdata_o <= ~d; // Stale data never looks valid
  endtask
endmodule // hpfa_host_bfm
`default_nettype wire

// ==== verif/hpfa_top_tb_top.sv ====
// Self-checking testbench for the host port FIFO access block
`default_nettype none
module hpfa_top_tb_top
  import hpfa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////
  // Bench signals
  logic        clk, rst, ce, slp, ack, psel, pen, pwr, perr, prdy;
  logic [7:0]  paddr, urd, utd, drd, dtd;
  logic [31:0] pwd, prd, q;
  logic [3:0]  pstrb, tep;
  logic        int_n, int_oe, dreq, urv, urr, utv, utr, tok, iso;
  logic        terr, sof, rpv, drv, drr, dtv, dtr, pu, pd, busy;
  logic [1:0]  csrc, den, dmode;
  logic [6:0]  taddr;
  hpfa_reply_e rpl;
  int          fails, check_count;
  // Device under test with a small FIFO
  hpfa_top #(.DEPTH(8)) dut (
    .core_clk_i(clk), .rst_i(rst), .ce_i(ce),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwd), .pstrb_i(pstrb), .prdata_o(prd), .pready_o(prdy),
    .pslverr_o(perr), .dma_acknowledge_pin_i(ack), .sleep_i(slp),
    .int_n_o(int_n), .int_oe_o(int_oe), .dma_req_o(dreq),
    .clock_source_choice_o(csrc), .usb_rx_valid_i(urv),
    .usb_rx_data_i(urd), .usb_rx_ready_o(urr), .usb_tx_valid_o(utv),
    .usb_tx_data_o(utd), .usb_tx_ready_i(utr), .usb_tok_i(tok),
    .usb_tok_addr_i(taddr), .usb_tok_ep_i(tep), .usb_tok_iso_i(iso),
    .usb_tok_err_i(terr), .usb_sof_i(sof), .usb_reply_valid_o(rpv),
    .usb_reply_o(rpl), .disk_rx_valid_i(drv), .disk_rx_data_i(drd),
    .disk_rx_ready_o(drr), .disk_tx_valid_o(dtv), .disk_tx_data_o(dtd),
    .disk_tx_ready_i(dtr), .disk_drive_enable_o(den),
    .disk_pullup_o(pu), .disk_pulldown_o(pd), .disk_mode_o(dmode),
    .disk_busy_o(busy)
  );
  // Host processor model
  hpfa_host_bfm host (
    .clk_i(clk), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr),
    .paddr_o(paddr), .pwdata_o(pwd), .pstrb_o(pstrb), .prdata_i(prd),
    .pready_i(prdy)
  );
  // Core clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Register access, outputs settled on return
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [3:0] s = 4'h3);
    host.xfer(1'b1, a, {16'h0000, d}, s, q);
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0000_0000, 4'h0, q);
    #1;
  endtask
  // Guarded setup and clock registers, paired byte writes
  task automatic t_guard();
    wr(A_SETUP, 16'h0003);
    rd(A_SETUP);
    chk(q[15:0], 16'h0000);
    wr(A_CLK, 16'h0002);
    chk({15'h0000, perr}, 16'h0000);
    chk({14'h0000, csrc}, 16'h0000);
    wr(A_GUARD, GUARD_KEY);
    wr(A_CLK, 16'h0002);
    chk({14'h0000, csrc}, 16'h0002);
    wr(A_USB_CFG, 16'h1234, 4'h1);
    rd(A_USB_CFG);
    chk(q[15:0], 16'h1234);
    wr(A_USB_CFG, 16'h0000, 4'h2);
    rd(A_USB_CFG);
    chk(q[15:0], 16'h0000);
    $display("t_guard done");
  endtask
  // DMA window, odd count, acknowledge pin and isolation
  task automatic t_dma();
    wr(A_SETUP, 16'h0002);
    wr(A_DMA_CNT, 16'h0005);
    chk({15'h0000, dreq}, 16'h0001);
    wr(A_DMA_WIN, 16'hBBAA);
    wr(A_DMA_WIN, 16'hDDCC);
    wr(A_DMA_WIN, 16'h99EE);
    rd(A_REM_LO);
    chk({8'h00, q[7:0]}, 16'h0005);
    chk({14'h0000, dreq, int_n}, 16'h0000);
    rd(A_FIFO_W);
    chk(q[15:0], 16'hBBAA);
    rd(A_FIFO_W);
    chk(q[15:0], 16'hDDCC);
    rd(A_BYTE_POP);
    chk({8'h00, q[7:0]}, 16'h00EE);
    @(posedge clk);
    ack <= 1'b0;
    wr(A_DMA_CNT, 16'h0002);
    wr(A_DMA_WIN, 16'h3344);
    rd(A_REM_LO);
    chk({8'h00, q[7:0]}, 16'h0000);
    @(posedge clk);
    slp <= 1'b1;
    wr(A_SETUP, 16'h0012);
    wr(A_DMA_WIN, 16'h3344);
    rd(A_FIFO_W);
    chk(q[15:0], 16'h3344);
    @(posedge clk);
    {ack, slp} <= 2'b10;
    $display("t_dma done");
  endtask
  // Interrupt drive style, alive during isolation
  task automatic t_int();
    logic [4:0] su [5] = '{5'h02, 5'h03, 5'h01, 5'h00, 5'h13};
    logic [1:0] ex [5] = '{2'b10, 2'b10, 2'b00, 2'b11, 2'b10};
    @(posedge clk);
    slp <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(A_SETUP, {11'h000, su[i]});
      chk({14'h0000, int_oe, int_n}, {14'h0000, ex[i]});
    end
    wr(A_SETUP, 16'h0000);
    @(posedge clk);
    slp <= 1'b0;
    $display("t_int done");
  endtask
  // Odd byte count via dummy byte, remain flag polling
  task automatic t_odd();
    logic ok;
    ok = 1'b0;
    wr(A_USB_CFG, 16'h0004);
    @(posedge clk);
    utr <= 1'b1;
    wr(A_FIFO_W, 16'hAA5A);
    wr(A_FIFO_W, 16'hCCBB);
    wr(A_FIFO_W, 16'hEEDD);
    rd(A_BYTE_POP);
    chk({8'h00, q[7:0]}, 16'h005A);
    rd(A_REM_LO);
    chk({8'h00, q[7:0]}, 16'h0005);
    chk({15'h0000, utv}, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      rd(A_REM_HI);
      ok = ok | q[15];
    end
    chk({15'h0000, ok}, 16'h0001);
    rd(A_FIFO_W);
    chk(q[15:0], 16'hBBAA);
    rd(A_FIFO_W);
    chk(q[15:0], 16'hDDCC);
    rd(A_BYTE_POP);
    chk({8'h00, q[7:0]}, 16'h00EE);
    @(posedge clk);
    utr <= 1'b0;
    $display("t_odd done");
  endtask
  // One token, reply judged the cycle after
  task automatic tk(input logic [6:0] a, input logic [3:0] e,
                    input logic i, input logic x, input logic [2:0] r);
    @(posedge clk);
    tok <= 1'b1;
    taddr <= a;
    tep <= e;
    iso <= i;
    terr <= x;
    @(posedge clk);
    tok <= 1'b0;
    #1;
    chk({13'h0000, rpv, rpl & {2{rpv}}}, {13'h0000, r});
  endtask
  // Reply filters and one iso per microframe
  task automatic t_reply();
    tk(7'h05, 4'h1, 1'b0, 1'b0, 3'b000);
    wr(A_USB_CFG, 16'h2058);
    tk(7'h05, 4'h1, 1'b0, 1'b0, 3'b101);
    tk(7'h06, 4'h1, 1'b0, 1'b0, 3'b000);
    tk(7'h05, 4'h4, 1'b0, 1'b0, 3'b000);
    tk(7'h05, 4'h3, 1'b0, 1'b1, 3'b000);
    tk(7'h05, 4'h3, 1'b1, 1'b0, 3'b101);
    tk(7'h05, 4'h3, 1'b1, 1'b0, 3'b000);
    @(posedge clk);
    sof <= 1'b1;
    @(posedge clk);
    sof <= 1'b0;
    tk(7'h05, 4'h3, 1'b1, 1'b0, 3'b101);
    wr(A_USB_CFG, 16'h205C);
    tk(7'h05, 4'h0, 1'b0, 1'b0, 3'b110);
    $display("t_reply done");
  endtask
  // Byte into the FIFO from USB or disk side
  task automatic push(input logic dsk, input logic [7:0] b);
    @(posedge clk);
    urv <= !dsk;
    drv <= dsk;
    urd <= b;
    drd <= b;
    do @(posedge clk); while ((dsk ? drr : urr) !== 1'b1);
    {urv, drv} <= 2'b00;
    urd <= ~b;
    drd <= ~b;
  endtask
  // Byte out towards USB or disk, checked
  task automatic pull(input logic dsk, input logic [7:0] b);
    @(posedge clk);
    utr <= !dsk;
    dtr <= dsk;
    do @(posedge clk); while ((dsk ? dtv : utv) !== 1'b1);
    {utr, dtr} <= 2'b00;
    chk({8'h00, (dsk ? dtd : utd)}, {8'h00, b});
  endtask
  // Packet-free FIFO use, disk pins, disk to USB path
  task automatic t_stream();
    wr(A_USB_CFG, 16'h2058);
    push(1'b0, 8'h11);
    push(1'b0, 8'h22);
    push(1'b0, 8'h33);
    rd(A_REM_LO);
    chk({8'h00, q[7:0]}, 16'h0003);
    pull(1'b0, 8'h11);
    pull(1'b0, 8'h22);
    pull(1'b0, 8'h33);
    wr(A_DISK_CFG, 16'h002B);
    chk({10'h000, den, pu, pd, dmode}, 16'h0036);
    wr(A_USB_CFG, 16'h2059);
    wr(A_DISK_CNT, 16'h0002);
    wr(A_DISK_GO, 16'h0001);
    chk({15'h0000, busy}, 16'h0001);
    push(1'b1, 8'h44);
    push(1'b1, 8'h55);
    pull(1'b0, 8'h44);
    pull(1'b0, 8'h55);
    wr(A_USB_CFG, 16'h205A);
    wr(A_DISK_CNT, 16'h0001);
    wr(A_DISK_GO, 16'h0001);
    push(1'b0, 8'h66);
    pull(1'b1, 8'h66);
    #1;
    chk({15'h0000, busy}, 16'h0000);
    wr(A_DISK_CFG, 16'h0000);
    chk({10'h000, den, pu, pd, dmode}, 16'h0000);
    $display("t_stream done");
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Reset, then the scenarios in turn
  initial begin
    ce = 1'b1;
    rst = 1'b1;
    ack = 1'b1;
    {slp, urv, utr, tok, iso, terr, sof, drv, dtr} = '0;
    {urd, drd, taddr, tep} = '0;
    fails = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_guard();
    t_dma();
    t_int();
    t_odd();
    t_reply();
    t_stream();
    wrap_up();
  end
  // Watchdog well past the expected run length
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    wrap_up();
  end
endmodule // hpfa_top_tb_top
`default_nettype wire
